// ---- design/chan_capture_compare.sv ----
`timescale 1ns/100ps
module chan_capture_compare
   import chan_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] counter,
   input wire logic counter_up,
   input wire logic period_start,
   input wire logic partner_match,
   input wire logic load_update,
   input wire logic debug_halt,
   input wire logic chan_pin_in,
   output logic chan_pin_out,
   output logic chan_pin_oe,
   output logic chan_event
);
   logic awready_q, awready_d, wready_q, wready_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wlane_q, wlane_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [3:0] ctrl_q, ctrl_d;
   logic [1:0] mode_q, mode_d;
   logic [1:0] edge_q, edge_d;
   logic [15:0] value_q, value_d;
   logic [15:0] rbuf_q, rbuf_d;
   logic rd_latched_q, rd_latched_d, rd_hi_q, rd_hi_d;
   logic [15:0] wbuf_q, wbuf_d;
   logic hi_seen_q, hi_seen_d, lo_seen_q, lo_seen_d;
   logic pending_q, pending_d;
   logic out_q, out_d, oe_q, oe_d, event_q, event_d;
   logic pin_rise, pin_fall;
   logic capture_mode, match, do_write;

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   pin_edge_sync u_sync
   (
      .clk(clk),
      .reset(reset),
      .pin(chan_pin_in),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic is_capture(input logic [3:0] c,
                                       input logic [1:0] m);
      is_capture = !c[PAIR_BIT] && !c[CPWM_BIT] && (m == MS_CAPTURE);
   endfunction

   function automatic logic [15:0] put_byte(input logic [15:0] v,
                                            input logic hi,
                                            input logic [7:0] b);
      put_byte = hi ? {b, v[7:0]} : {v[15:8], b};
   endfunction

   assign capture_mode = is_capture(ctrl_q, mode_q);
   assign match = (counter == value_q);
   assign do_write = aw_have_q && w_have_q && !bvalid_q;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      aw_addr_d = aw_addr_q;
      wdata_d = wdata_q;
      wlane_d = wlane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      ctrl_d = ctrl_q;
      mode_d = mode_q;
      edge_d = edge_q;
      value_d = value_q;
      rbuf_d = rbuf_q;
      rd_latched_d = rd_latched_q;
      rd_hi_d = rd_hi_q;
      wbuf_d = wbuf_q;
      hi_seen_d = hi_seen_q;
      lo_seen_d = lo_seen_q;
      pending_d = pending_q;
      out_d = out_q;
      event_d = 1'b0;
      oe_d = (edge_q != EL_OFF);

      // Buffered load of a completed pair
      if (pending_q && load_update && !debug_halt)
      begin
         value_d = wbuf_q;
         pending_d = 1'b0;
      end

      // Channel behaviour
      if (ctrl_q[PAIR_BIT])
      begin
         if (match)
         begin
            event_d = 1'b1;
            out_d = (edge_q == EL_HIGH_TRUE);
         end
         else if (partner_match)
         begin
            out_d = (edge_q != EL_HIGH_TRUE);
         end
      end
      else if (ctrl_q[CPWM_BIT])
      begin
         if (match)
         begin
            event_d = 1'b1;
            if (edge_q == EL_HIGH_TRUE)
            begin
               out_d = !counter_up;
            end
            else
            begin
               out_d = counter_up;
            end
         end
      end
      else if (mode_q == MS_CAPTURE)
      begin
         if ((edge_q[0] && pin_rise) || (edge_q[1] && pin_fall))
         begin
            value_d = counter;
            event_d = 1'b1;
         end
      end
      else if (mode_q == MS_COMPARE)
      begin
         if (match)
         begin
            event_d = 1'b1;
            case (edge_q)
               OC_TOGGLE: out_d = !out_q;
               OC_CLEAR: out_d = 1'b0;
               OC_SET: out_d = 1'b1;
               default: out_d = out_q;
            endcase
         end
      end
      else
      begin
         if (match)
         begin
            event_d = 1'b1;
            out_d = (edge_q != EL_HIGH_TRUE);
         end
         else if (period_start)
         begin
            out_d = (edge_q == EL_HIGH_TRUE);
         end
      end

      // Write channels
      if (s_axi_awvalid && awready_q)
      begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata[7:0];
         wlane_d = s_axi_wstrb[0];
      end
      if (bvalid_q && s_axi_bready)
      begin
         bvalid_d = 1'b0;
      end
      if (do_write)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = RESP_OKAY;
         if (aw_addr_q == CSC_OFFS)
         begin
            if (wlane_q && ctrl_q[WPD_BIT])
            begin
               mode_d = wdata_q[MS_HI_BIT:MS_LO_BIT];
               edge_d = wdata_q[EL_HI_BIT:EL_LO_BIT];
            end
            rd_latched_d = 1'b0;
            if (!ctrl_q[FEN_BIT])
            begin
               hi_seen_d = 1'b0;
               lo_seen_d = 1'b0;
            end
         end
         else if ((aw_addr_q == VH_OFFS) || (aw_addr_q == VL_OFFS))
         begin
            if (!wlane_q || capture_mode)
            begin
               bresp_d = RESP_OKAY;
            end
            else if (debug_halt)
            begin
               value_d = put_byte(value_d, aw_addr_q == VH_OFFS,
                                  wdata_q);
            end
            else
            begin
               wbuf_d = put_byte(wbuf_q, aw_addr_q == VH_OFFS,
                                 wdata_q);
               if (aw_addr_q == VH_OFFS)
               begin
                  hi_seen_d = 1'b1;
               end
               else
               begin
                  lo_seen_d = 1'b1;
               end
               if (hi_seen_d && lo_seen_d)
               begin
                  pending_d = 1'b1;
                  hi_seen_d = 1'b0;
                  lo_seen_d = 1'b0;
               end
            end
         end
         else if (aw_addr_q == CTRL_OFFS)
         begin
            if (wlane_q)
            begin
               ctrl_d = wdata_q[3:0];
            end
         end
         else if (aw_addr_q != STAT_OFFS)
         begin
            bresp_d = RESP_SLVERR;
         end
      end

      // Read channels
      if (rvalid_q && s_axi_rready)
      begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
      if (s_axi_arvalid && arready_q)
      begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = 32'h0000_0000;
         if (s_axi_araddr == CSC_OFFS)
         begin
            rdata_d[MS_HI_BIT:MS_LO_BIT] = mode_q;
            rdata_d[EL_HI_BIT:EL_LO_BIT] = edge_q;
         end
         else if ((s_axi_araddr == VH_OFFS) || (s_axi_araddr == VL_OFFS))
         begin
            if (!capture_mode || debug_halt)
            begin
               rdata_d[15:0] = value_q;
            end
            else if (rd_latched_q)
            begin
               rdata_d[15:0] = rbuf_q;
               if (rd_hi_q != (s_axi_araddr == VH_OFFS))
               begin
                  rd_latched_d = 1'b0;
               end
            end
            else
            begin
               rdata_d[15:0] = value_q;
               rbuf_d = value_q;
               rd_latched_d = 1'b1;
               rd_hi_d = (s_axi_araddr == VH_OFFS);
            end
            if (s_axi_araddr == VH_OFFS)
            begin
               rdata_d[15:0] = {8'h00, rdata_d[15:8]};
            end
            else
            begin
               rdata_d[15:8] = 8'h00;
            end
         end
         else if (s_axi_araddr == CTRL_OFFS)
         begin
            rdata_d[3:0] = ctrl_q;
         end
         else if (s_axi_araddr == STAT_OFFS)
         begin
            rdata_d[4:0] = {lo_seen_q, hi_seen_q, pending_q,
                            rd_latched_q, out_q};
         end
         else
         begin
            rresp_d = RESP_SLVERR;
         end
      end

      awready_d = !aw_have_d && !bvalid_d;
      wready_d = !w_have_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         wdata_q <= 8'h00;
         wlane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
         ctrl_q <= CTRL_RESET;
         mode_q <= MODE_RESET;
         edge_q <= EDGE_RESET;
         value_q <= VALUE_RESET;
         rbuf_q <= VALUE_RESET;
         rd_latched_q <= 1'b0;
         rd_hi_q <= 1'b0;
         wbuf_q <= VALUE_RESET;
         hi_seen_q <= 1'b0;
         lo_seen_q <= 1'b0;
         pending_q <= 1'b0;
         out_q <= 1'b0;
         oe_q <= 1'b0;
         event_q <= 1'b0;
      end
      else
      begin
         awready_q <= awready_d;
         wready_q <= wready_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         aw_addr_q <= aw_addr_d;
         wdata_q <= wdata_d;
         wlane_q <= wlane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         ctrl_q <= ctrl_d;
         mode_q <= mode_d;
         edge_q <= edge_d;
         value_q <= value_d;
         rbuf_q <= rbuf_d;
         rd_latched_q <= rd_latched_d;
         rd_hi_q <= rd_hi_d;
         wbuf_q <= wbuf_d;
         hi_seen_q <= hi_seen_d;
         lo_seen_q <= lo_seen_d;
         pending_q <= pending_d;
         out_q <= out_d;
         oe_q <= oe_d;
         event_q <= event_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign chan_pin_out = out_q;
   assign chan_pin_oe = oe_q;
   assign chan_event = event_q;
endmodule

// ---- design/chan_pkg.sv ----
package chan_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [7:0] CSC_OFFS = 8'h00;
   localparam logic [7:0] VH_OFFS = 8'h04;
   localparam logic [7:0] VL_OFFS = 8'h08;
   localparam logic [7:0] CTRL_OFFS = 8'h0C;
   localparam logic [7:0] STAT_OFFS = 8'h10;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int MS_HI_BIT = 5;
   localparam int MS_LO_BIT = 4;
   localparam int EL_HI_BIT = 3;
   localparam int EL_LO_BIT = 2;
   localparam int WPD_BIT = 0;
   localparam int FEN_BIT = 1;
   localparam int CPWM_BIT = 2;
   localparam int PAIR_BIT = 3;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [3:0] CTRL_RESET = 4'h1;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] EDGE_RESET = 2'h0;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   // ----------------------------------------
   // Codes
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] EL_OFF = 2'h0;
   localparam logic [1:0] EL_HIGH_TRUE = 2'h2;
   localparam logic [1:0] MS_CAPTURE = 2'h0;
   localparam logic [1:0] MS_COMPARE = 2'h1;
   typedef enum logic [1:0]
   {
      OC_TOGGLE = 2'b01,
      OC_CLEAR = 2'b10,
      OC_SET = 2'b11
   } oc_action_e;
endpackage

// ---- design/pin_edge_sync.sv ----
`timescale 1ns/100ps
module pin_edge_sync
   import chan_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic prev_q, prev_d;

   // ----------------------------------------
   // Two-stage synchroniser and edge detect
   // ----------------------------------------
   always_comb
   begin
      meta_d = pin;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // One-cycle pulse on each change of the synchronised input
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule

// ---- dv/chan_capture_compare_monitor.sv ----
`timescale 1ns/100ps
module chan_capture_compare_monitor
   import chan_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic chan_pin_oe
);
   logic aw_bad_q, aw_bad_d, ar_bad_q, ar_bad_d;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic bad(input logic [7:0] a);
      return a > STAT_OFFS || a[1:0] != 2'h0;
   endfunction
   always_comb
   begin
      aw_bad_d = aw_bad_q;
      ar_bad_d = ar_bad_q;
      if (s_axi_awvalid && s_axi_awready)
         aw_bad_d = bad(s_axi_awaddr);
      if (s_axi_arvalid && s_axi_arready)
         ar_bad_d = bad(s_axi_araddr);
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         aw_bad_q <= 1'h0;
         ar_bad_q <= 1'h0;
      end
      else
      begin
         aw_bad_q <= aw_bad_d;
         ar_bad_q <= ar_bad_d;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_aw_drop: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready high after address taken");
   a_w_drop: assert property (
      s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("wready high after data taken");
   a_b_time: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_b_code: assert property (
      s_axi_bvalid |-> s_axi_bresp == (aw_bad_q ? RESP_SLVERR : RESP_OKAY))
      else $error("wrong write response code");
   a_r_time: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_r_code: assert property (
      s_axi_rvalid |-> s_axi_rresp == (ar_bad_q ? RESP_SLVERR : RESP_OKAY))
      else $error("wrong read response code");
   a_oe_cause: assert property (
      $changed(chan_pin_oe) |-> $past(s_axi_bvalid))
      else $error("pin enable changed without a write");
endmodule
bind chan_capture_compare chan_capture_compare_monitor u_mon (.*);

// ---- dv/chan_pin_model.sv ----
`timescale 1ns/100ps
module chan_pin_model
(
   input wire logic clk,
   input wire logic level,
   output logic pin
);
   logic pin_q = 1'h0;
   // ----------------------------------------
   // Pin driver
   // ----------------------------------------
   always_ff @(posedge clk)
      pin_q <= level;
   assign pin = pin_q;
endmodule

// ---- dv/timer_channel_mode_and_value_test.sv ----
`timescale 1ns/100ps
module timer_channel_mode_and_value_test;
   import chan_pkg::*;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rq;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, level = 1'h0;
   logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [15:0] counter = 16'h0000;
   logic counter_up = 1'h1, period_start = 1'h0, partner_match = 1'h0;
   logic load_update = 1'h0, debug_halt = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, chan_pin_in, chan_pin_out, chan_pin_oe, chan_event;
   logic [1:0] s_axi_bresp, s_axi_rresp, bq, rrq;
   int mismatches = 0, checked = 0, ev = 0, e0;
   chan_capture_compare u_dut (.*);
   chan_pin_model u_pin (.clk(clk), .level(level), .pin(chan_pin_in));
   initial
      forever #10 clk = ~clk;
   always @(posedge clk)
      if (chan_event === 1'h1)
         ev <= ev + 1;
   // ----------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return s_axi_awready && s_axi_wready;
         1: return s_axi_bvalid;
         2: return s_axi_arready;
         default: return s_axi_rvalid;
      endcase
   endfunction
   task automatic await(input int s);
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
         bq = s_axi_bresp;
         rq = s_axi_rdata[7:0];
         rrq = s_axi_rresp;
      end while (!sig(s) && n < 200);
      if (!sig(s))
      begin
         mismatches++;
         test_done();
      end
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = RESP_OKAY);
      logic aw_on, w_on;
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      aw_on = 1'h1;
      w_on = 1'h1;
      n = 0;
      while ((aw_on || w_on) && n < 200)
      begin
         @(negedge clk);
         n++;
         aw_on = aw_on && !s_axi_awready;
         w_on = w_on && !s_axi_wready;
         @(posedge clk);
         s_axi_awvalid <= aw_on;
         s_axi_wvalid <= w_on;
      end
      if (aw_on || w_on)
      begin
         mismatches++;
         test_done();
      end
      await(1);
      s_axi_bready <= 1'h0;
      cmp(16'(bq), 16'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      await(2);
      s_axi_arvalid <= 1'h0;
      @(posedge clk);
      s_axi_rready <= 1'h1;
      await(3);
      s_axi_rready <= 1'h0;
      cmp(16'({rrq, rq}), 16'({RESP_OKAY, e}));
   endtask
   task automatic act(input int k);
      @(posedge clk);
      case (k)
         0: counter <= 16'h1234;
         1: period_start <= 1'h1;
         2: partner_match <= 1'h1;
         default: load_update <= 1'h1;
      endcase
      @(posedge clk);
      counter <= 16'h0000;
      period_start <= 1'h0;
      partner_match <= 1'h0;
      load_update <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic step(input logic [3:0] c, input logic [7:0] m,
                       input int k, input int e);
      logic p;
      wr(CTRL_OFFS, {4'h0, c});
      wr(CSC_OFFS, m);
      p = chan_pin_out;
      act(k);
      cmp(16'({chan_pin_oe, chan_pin_out}), 16'({1'h1, e == 2 ? ~p : e[0]}));
   endtask
   task automatic edge_to(input logic l);
      @(posedge clk);
      level <= l;
      repeat (8) @(posedge clk);
   endtask
   task automatic cap(input logic [15:0] v);
      @(posedge clk);
      counter <= v;
      edge_to(1'h1);
      edge_to(1'h0);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'h0;
      repeat (2) @(posedge clk);
      rd(CSC_OFFS, 8'h00);
      rd(VH_OFFS, 8'h00);
      rd(VL_OFFS, 8'h00);
      rd(CTRL_OFFS, 8'h01);
      wr(8'h14, 8'h00, RESP_SLVERR);
      wr(CTRL_OFFS, 8'h00);
      wr(CSC_OFFS, 8'h1C);
      rd(CSC_OFFS, 8'h00);
      wr(CTRL_OFFS, 8'h01);
      wr(CSC_OFFS, 8'h18);
      rd(CSC_OFFS, 8'h18);
      wr(VH_OFFS, 8'h77);
      wr(CSC_OFFS, 8'h18);
      wr(VL_OFFS, 8'h99);
      act(3);
      rd(VH_OFFS, 8'h00);
      wr(CSC_OFFS, 8'h18);
      wr(VH_OFFS, 8'hAB);
      debug_halt <= 1'h1;
      wr(VL_OFFS, 8'h56);
      rd(VL_OFFS, 8'h56);
      debug_halt <= 1'h0;
      wr(VL_OFFS, 8'hCD);
      act(3);
      rd(VH_OFFS, 8'hAB);
      rd(VL_OFFS, 8'hCD);
      wr(VH_OFFS, 8'h12);
      act(3);
      rd(VH_OFFS, 8'hAB);
      wr(VL_OFFS, 8'h34);
      rd(VL_OFFS, 8'hCD);
      act(3);
      rd(VH_OFFS, 8'h12);
      rd(VL_OFFS, 8'h34);
      step(4'h1, 8'h1C, 0, 1);
      step(4'h1, 8'h18, 0, 0);
      step(4'h1, 8'h14, 0, 2);
      step(4'h1, 8'h14, 0, 2);
      step(4'h1, 8'h28, 1, 1);
      step(4'h1, 8'h28, 0, 0);
      step(4'h1, 8'h24, 1, 0);
      step(4'h1, 8'h24, 0, 1);
      step(4'h5, 8'h08, 0, 0);
      step(4'h5, 8'h04, 0, 1);
      step(4'h9, 8'h08, 0, 1);
      step(4'h9, 8'h08, 2, 0);
      step(4'h9, 8'h04, 0, 0);
      step(4'h9, 8'h04, 2, 1);
      wr(CTRL_OFFS, 8'h01);
      wr(CSC_OFFS, 8'h10);
      e0 = ev;
      act(0);
      cmp(16'(ev - e0), 16'h0001);
      cmp(16'(chan_pin_oe), 16'h0000);
      for (int c = 1; c < 4; c++)
      begin
         wr(CSC_OFFS, 8'(c << 2));
         e0 = ev;
         edge_to(1'h1);
         cmp(16'(ev - e0), 16'(c & 1));
         edge_to(1'h0);
         cmp(16'(ev - e0), 16'((c & 1) + (c >> 1)));
      end
      wr(CSC_OFFS, 8'h04);
      cap(16'hABCD);
      wr(VH_OFFS, 8'hFF);
      rd(VH_OFFS, 8'hAB);
      cap(16'h5678);
      rd(VL_OFFS, 8'hCD);
      rd(VH_OFFS, 8'h56);
      rd(VH_OFFS, 8'h56);
      cap(16'h9ABC);
      wr(CSC_OFFS, 8'h04);
      rd(VL_OFFS, 8'hBC);
      cap(16'h1357);
      debug_halt <= 1'h1;
      rd(VH_OFFS, 8'h13);
      wr(CSC_OFFS, 8'h04);
      debug_halt <= 1'h0;
      rd(VH_OFFS, 8'h13);
      test_done();
   end
endmodule
